// ### include/incr_jump_pkg.sv
// Constants and types shared by the increment/OR/jump execution unit
// Notes on behaviour
// - Increment adds one to a file register; select bit picks accumulator or register.
// - Increment-and-skip with zero result discards next instruction; two cycles; no flags.
// - Increment-and-skip with nonzero result continues normally; result still written.
// - Jump loads its eleven-bit operand into program counter bits 10..0.
// - Jump fills program counter bits 12..11 from upper latch bits 4..3.
// - Jump takes two instruction cycles and changes no status flag.
// - OR-with-literal ORs accumulator with eight-bit literal into accumulator; zero updated.
// - OR-with-register ORs accumulator with file register into selected target; zero updated.
// - The zero flag is set by any flag-affecting operation with zero result.
package incr_jump_pkg;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;
   localparam int FILE_DEPTH = 128;
   // Opcode fields, compared against the top bits of the instruction word
   localparam logic [5:0] OPC_INCR = 6'h0A;
   localparam logic [5:0] OPC_INCR_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_REG = 6'h04;
   localparam logic [5:0] OPC_OR_LIT = 6'h38;
   localparam logic [2:0] OPC_JUMP = 3'h5;
   localparam int DEST_BIT = 7;
   localparam int LATCH_JUMP_LO = 3;
   // Field positions inside the instruction word
   localparam int OPC_LSB = 8;
   localparam int JUMP_OPC_LSB = 11;
   // Clocks per instruction cycle: operand read, then execute
   localparam int CLK_PER_ICYC = 2;
   // Software port map
   localparam logic [3:0] OFS_ACC = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_PCLATCH = 4'h2;
   localparam logic [3:0] OFS_PCLO = 4'h3;
   localparam logic [3:0] OFS_PCHI = 4'h4;
   localparam int STAT_ZERO = 0;
   localparam int STAT_BUSY = 1;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [4:0] PCLATCH_RST = 5'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic ZERO_RST = 1'b0;
   localparam logic READY_RST = 1'b1;
   localparam logic [13:0] INSTR_RST = 14'h0000;
   localparam logic [1:0] DISCARD_RST = 2'h0;
   localparam logic [7:0] SWRD_RST = 8'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DISCARD} exec_state_t;
endpackage

// ### include/file_port_if.sv
// Port between the execution unit and the file register memory
`timescale 1ns/100ps
`default_nettype none
interface file_port_if;
   logic [6:0] addr;
   logic wrEn;
   logic [7:0] wrData;
   logic [7:0] rdData;
   modport ctrl (output addr, output wrEn, output wrData, input rdData);
   modport mem (input addr, input wrEn, input wrData, output rdData);
endinterface
`default_nettype wire

// ### rtl/file_reg_mem.sv
// File register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module file_reg_mem (
   input wire logic sys_clk,
   file_port_if.mem port
);
   logic [7:0] store [0:incr_jump_pkg::FILE_DEPTH-1];
   logic [7:0] rdData_ff;

   // Read returns the old value when address is also written
   always_ff @(posedge sys_clk) begin
      if (port.wrEn) begin
         store[port.addr] <= port.wrData;
      end
      rdData_ff <= store[port.addr];
   end

   assign port.rdData = rdData_ff;
endmodule
`default_nettype wire

// ### rtl/incr_or_jump_exec.sv
// Execution unit for increment, increment-skip, OR and absolute jump
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module incr_or_jump_exec (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic instrValid,
   input wire logic [13:0] instrWord,
   output logic instrReady,
   output logic [12:0] pc,
   output logic [7:0] acc,
   output logic zeroFlag,
   input wire logic [3:0] swAddr,
   input wire logic [7:0] swWrData,
   input wire logic swWr,
   input wire logic swRd,
   output logic [7:0] swRdData
);
   file_port_if fport ();

   file_reg_mem i_file_reg_mem (
      .sys_clk(sys_clk),
      .port(fport.mem)
   );

   incr_jump_pkg::exec_state_t state_ff, nxt_state;
   logic [13:0] instr_ff;
   logic [12:0] pc_ff, nxt_pc;
   logic [7:0] acc_ff, nxt_acc;
   logic zero_ff, nxt_zero;
   logic [4:0] pcLatch_ff;
   logic ready_ff;
   logic [7:0] swRd_ff;
   logic [1:0] discardCnt_ff;

   // Fields of the held word; the address field follows the incoming word
   wire [13:0] curInstr = (state_ff == incr_jump_pkg::ST_IDLE) ?
      instrWord : instr_ff;
   wire [5:0] opField = instr_ff[incr_jump_pkg::OPC_LSB +: 6];
   wire [2:0] jumpField = instr_ff[incr_jump_pkg::JUMP_OPC_LSB +: 3];
   wire [7:0] litField = instr_ff[7:0];
   wire [10:0] jumpTarget = instr_ff[10:0];
   wire [6:0] fileAddr = curInstr[6:0];

   // Decode of the held instruction
   wire isIncr = opField == incr_jump_pkg::OPC_INCR;
   wire isIncrSkip = opField == incr_jump_pkg::OPC_INCR_SKIP;
   wire isOrReg = opField == incr_jump_pkg::OPC_OR_REG;
   wire isOrLit = opField == incr_jump_pkg::OPC_OR_LIT;
   wire isJump = jumpField == incr_jump_pkg::OPC_JUMP;
   wire toFile = instr_ff[incr_jump_pkg::DEST_BIT];
   wire [7:0] operand = fport.rdData;
   wire [7:0] incSum = operand + 8'h01;
   wire [7:0] orReg = acc_ff | operand;
   wire [7:0] orLit = acc_ff | litField;
   wire isIncAny = isIncr | isIncrSkip;
   wire [7:0] result = isIncAny ? incSum : (isOrReg ? orReg : orLit);
   wire regOp = isIncAny | isOrReg;
   // Increment-and-skip is left out: it never touches the flags
   wire flagOp = isIncr | isOrReg | isOrLit;
   wire skipNow = isIncrSkip & (incSum == 8'h00);
   wire [12:0] jumpPc = {pcLatch_ff[incr_jump_pkg::LATCH_JUMP_LO +: 2],
      jumpTarget};
   wire inExec = state_ff == incr_jump_pkg::ST_EXEC;
   wire inDiscard = state_ff == incr_jump_pkg::ST_DISCARD;
   wire twoCycle = isJump | skipNow;
   wire accept = (state_ff == incr_jump_pkg::ST_IDLE) & instrValid;
   // The idle operation lasts one full instruction cycle
   wire discardDone = discardCnt_ff ==
      2'(incr_jump_pkg::CLK_PER_ICYC - 1);
   wire [1:0] nxt_discardCnt = (inDiscard && !discardDone) ?
      discardCnt_ff + 2'h1 : 2'h0;

   // Memory address follows the incoming word so the operand is ready next
   assign fport.addr = fileAddr;
   assign fport.wrEn = inExec & regOp & toFile;
   assign fport.wrData = result;

   // Next state and program counter
   always_comb begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      case (state_ff)
         incr_jump_pkg::ST_IDLE: begin
            if (instrValid) begin
               nxt_state = incr_jump_pkg::ST_EXEC;
            end
         end
         incr_jump_pkg::ST_EXEC: begin
            if (isJump) begin
               nxt_pc = jumpPc;
            end else if (skipNow) begin
               nxt_pc = pc_ff + 13'h0002;
            end else begin
               nxt_pc = pc_ff + 13'h0001;
            end
            nxt_state = twoCycle ? incr_jump_pkg::ST_DISCARD :
               incr_jump_pkg::ST_IDLE;
         end
         incr_jump_pkg::ST_DISCARD: begin
            // Idle operation fills the second instruction cycle
            if (discardDone) begin
               nxt_state = incr_jump_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = incr_jump_pkg::ST_IDLE;
         end
      endcase
   end

   // Accumulator and zero flag; execution wins over a software write
   always_comb begin
      nxt_acc = acc_ff;
      nxt_zero = zero_ff;
      if (inExec && ((regOp && !toFile) || isOrLit)) begin
         nxt_acc = result;
      end else if (swWr && swAddr == incr_jump_pkg::OFS_ACC) begin
         nxt_acc = swWrData;
      end
      if (inExec && flagOp) begin
         nxt_zero = (result == 8'h00);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= incr_jump_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= incr_jump_pkg::PC_RST;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= incr_jump_pkg::ACC_RST;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_ff <= incr_jump_pkg::ZERO_RST;
      end else begin
         zero_ff <= nxt_zero;
      end
   end

   // Word is held through execution so the fetch side may move on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_ff <= incr_jump_pkg::INSTR_RST;
      end else if (accept) begin
         instr_ff <= instrWord;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         discardCnt_ff <= incr_jump_pkg::DISCARD_RST;
      end else begin
         discardCnt_ff <= nxt_discardCnt;
      end
   end

   // Ready follows the next state so it rises in the idle cycle itself
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_ff <= incr_jump_pkg::READY_RST;
      end else begin
         ready_ff <= nxt_state == incr_jump_pkg::ST_IDLE;
      end
   end

   // Software port: upper latch write, registered read data
   wire swHitLatch = swAddr == incr_jump_pkg::OFS_PCLATCH;
   wire hitAcc = swAddr == incr_jump_pkg::OFS_ACC;
   wire hitStatus = swAddr == incr_jump_pkg::OFS_STATUS;
   wire hitPcLo = swAddr == incr_jump_pkg::OFS_PCLO;
   wire hitPcHi = swAddr == incr_jump_pkg::OFS_PCHI;
   wire busy = ~ready_ff;
   wire [7:0] zeroBit = 8'(zero_ff) << incr_jump_pkg::STAT_ZERO;
   wire [7:0] busyBit = 8'(busy) << incr_jump_pkg::STAT_BUSY;
   wire [7:0] statusWord = zeroBit | busyBit;
   wire [7:0] latchWord = {3'h0, pcLatch_ff};
   wire [7:0] pcHiWord = {3'h0, pc_ff[12:8]};
   // Unmapped offsets read as zero
   wire [7:0] swMux = hitAcc ? acc_ff :
      hitStatus ? statusWord :
      swHitLatch ? latchWord :
      hitPcLo ? pc_ff[7:0] :
      hitPcHi ? pcHiWord : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcLatch_ff <= incr_jump_pkg::PCLATCH_RST;
      end else if (swWr && swHitLatch) begin
         pcLatch_ff <= swWrData[4:0];
      end
   end

   // Read data fall back to zero so a stale value is never seen twice
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         swRd_ff <= incr_jump_pkg::SWRD_RST;
      end else begin
         swRd_ff <= swRd ? swMux : 8'h00;
      end
   end

   assign instrReady = ready_ff;
   assign pc = pc_ff;
   assign acc = acc_ff;
   assign zeroFlag = zero_ff;
   assign swRdData = swRd_ff;
endmodule
`default_nettype wire

// ### testbench/incr_or_jump_exec_assertions.sv
// Concurrent checks on the execution unit's instruction port
`timescale 1ns/100ps
`default_nettype none
module incr_or_jump_exec_assertions (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic instrValid,
   input wire logic [13:0] instrWord,
   input wire logic instrReady,
   input wire logic [12:0] pc,
   input wire logic [7:0] acc,
   input wire logic zeroFlag
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire tk = instrValid && instrReady;
   wire [5:0] op = instrWord[13:8];
   wire isJmp = tk && instrWord[13:11] == incr_jump_pkg::OPC_JUMP;
   wire isSkp = tk && op == incr_jump_pkg::OPC_INCR_SKIP;
   wire isLit = tk && op == incr_jump_pkg::OPC_OR_LIT;
   wire toAcc = tk && !instrWord[7];
   wire isInc = toAcc && op == incr_jump_pkg::OPC_INCR;
   wire isOr = toAcc && op == incr_jump_pkg::OPC_OR_REG;
   wire isStep = tk && !isJmp && !isSkp;
   sequence longWait; !instrReady[*3] ##1 instrReady; endsequence
   sequence shortWait; !instrReady ##1 instrReady; endsequence
   jump_target_a: assert property (isJmp |=> ##1
      pc[10:0] == $past(instrWord[10:0], 2)) else $error("jump target wrong");
   jump_wait_a: assert property (isJmp |=> longWait)
      else $error("jump length wrong");
   jump_flag_a: assert property (isJmp |=> $stable(zeroFlag)[*4])
      else $error("jump changed zero flag");
   skip_flag_a: assert property (isSkp |=> $stable(zeroFlag)[*3])
      else $error("skip changed zero flag");
   step_wait_a: assert property (isStep |=> shortWait)
      else $error("single cycle length wrong");
   step_pc_a: assert property (isStep |=> ##1
      pc == $past(pc, 2) + 13'h0001) else $error("pc did not advance");
   lit_or_a: assert property (isLit |=> ##1
      acc == ($past(acc, 2) | $past(instrWord[7:0], 2))) else $error("or lit");
   lit_zero_a: assert property (isLit |=> ##1
      zeroFlag == (acc == 8'h00)) else $error("zero flag after or literal");
   inc_zero_a: assert property (isInc |=> ##1
      zeroFlag == (acc == 8'h00)) else $error("zero flag after increment");
   reg_or_a: assert property (isOr |=> ##1
      (acc & $past(acc, 2)) == $past(acc, 2)) else $error("or lost bits");
   reg_zero_a: assert property (isOr |=> ##1
      zeroFlag == (acc == 8'h00)) else $error("zero flag after or register");
endmodule
`default_nettype wire

// ### testbench/fetch_model.sv
// Instruction fetch model: a small program store read at the pc
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
   input wire logic run,
   input wire logic instrReady,
   input wire logic [12:0] pc,
   output logic instrValid,
   output logic [13:0] instrWord
);
   logic [13:0] prog [0:31];
   // Only low pc bits index the store, so far jumps alias onto it
   assign instrValid = run && instrReady;
   assign instrWord = prog[pc[4:0]];
endmodule
`default_nettype wire

// ### testbench/incr_or_jump_exec_tb.sv
// Self-checking bench for the increment/OR/jump execution unit
`timescale 1ns/100ps
`default_nettype none
module incr_or_jump_exec_tb;
   logic sys_clk = 0, rst_n = 0, run = 0, swWr = 0, swRd = 0;
   logic instrValid, instrReady, zeroFlag;
   logic [13:0] instrWord;
   logic [12:0] pc;
   logic [7:0] acc, swRdData, swWrData = 0;
   logic [3:0] swAddr = 0;
   int err_count = 0, comparisons = 0, i;
   // Skip at 3 hides the increment at 4; the one at 5 must not skip
   logic [13:0] code [0:7] = '{14'h3800, 14'h38FF, 14'h0490, 14'h0F90,
      14'h0A90, 14'h0F90, 14'h0A10, 14'h2814};
   always #2 sys_clk = ~sys_clk;
   fetch_model i_fetch_model (.run, .instrReady, .pc, .instrValid,
      .instrWord);
   incr_or_jump_exec i_incr_or_jump_exec (.sys_clk, .rst_n, .instrValid,
      .instrWord, .instrReady, .pc, .acc, .zeroFlag, .swAddr, .swWrData,
      .swWr, .swRd, .swRdData);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      swAddr <= a;
      swWrData <= d;
      swWr <= 1'b1;
      @(posedge sys_clk);
      swWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      swAddr <= a;
      swRd <= 1'b1;
      @(posedge sys_clk);
      swRd <= 1'b0;
      @(negedge sys_clk);
      chk(swRdData, exp);
   endtask
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      for (i = 0; i < 32; i++) i_fetch_model.prog[i] = 14'h0000;
      for (i = 0; i < 8; i++) i_fetch_model.prog[i] = code[i];
      i_fetch_model.prog[20] = 14'h3880;
      i_fetch_model.prog[21] = 14'h0410;
      i_fetch_model.prog[22] = 14'h2816;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h3C);
      rd(4'h0, 8'h3C);
      wr(4'h1, 8'hFF);
      rd(4'h1, 8'h00);
      rd(4'h7, 8'h00);
      wr(4'h2, 8'h18);
      wr(4'h0, 8'h00);
      @(posedge sys_clk);
      run <= 1'b1;
      // Look at pc away from the edge that updates it
      for (i = 0; i < 300 && pc !== 13'h1816; i++) @(negedge sys_clk);
      if (i == 300) begin
         err_count++;
         summarize();
      end
      @(posedge sys_clk);
      run <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rd(4'h0, 8'h83);
      chk(acc, 8'h83);
      rd(4'h1, 8'h00);
      chk({7'h00, zeroFlag}, 8'h00);
      rd(4'h3, 8'h16);
      chk(pc[7:0], 8'h16);
      rd(4'h4, 8'h18);
      chk({3'h0, pc[12:8]}, 8'h18);
      summarize();
   end
endmodule
bind incr_or_jump_exec incr_or_jump_exec_assertions
   i_incr_or_jump_exec_assertions (.sys_clk, .rst_n, .instrValid,
   .instrWord, .instrReady, .pc, .acc, .zeroFlag);
`default_nettype wire
